// ===== src/tcc_pkg.sv
// Constants and types for the timer compare/capture channel
package tcc_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 20;
	localparam int          DATA_W        = 32;
	localparam int          REG_W         = 16;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_TIMER_CTL = 16'h5400;
	localparam logic [15:0] IDX_COUNTER   = 16'h5402;
	localparam logic [15:0] IDX_MODE_CTL  = 16'h5404;
	localparam logic [15:0] IDX_A_DATA    = 16'h5406;
	localparam logic [15:0] IDX_B_DATA    = 16'h5408;
	localparam logic [15:0] IDX_IRQ_EN    = 16'h540A;
	localparam logic [15:0] IDX_IRQ_FLAG  = 16'h540C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          TCTL_RUN      = 0;
	localparam int          TCTL_BUF      = 1;
	localparam int          CTL_A_MODE    = 0;
	localparam int          CTL_A_INV     = 1;
	localparam int          CTL_A_WAVE    = 4;
	localparam int          CTL_A_EDGE    = 6;
	localparam int          CTL_B_MODE    = 8;
	localparam int          CTL_B_EDGE    = 14;
	localparam int          IRQ_CMP_A     = 0;
	localparam int          IRQ_CMP_B     = 1;
	localparam int          IRQ_CAP_A     = 2;
	localparam int          IRQ_CAP_B     = 3;
	localparam int          IRQ_OVW_A     = 4;
	localparam int          IRQ_OVW_B     = 5;
	localparam int          IRQ_W         = 6;

	// ----------------------------------------------------------------
	// Masks, reset values and timing
	// ----------------------------------------------------------------
	localparam logic [15:0] TCTL_MASK     = 16'h0003;
	localparam logic [15:0] MODE_CTL_MASK = 16'hC1F3;
	localparam logic [15:0] REG_RESET     = 16'h0000;
	localparam logic [5:0]  IRQ_RESET     = 6'h00;
	localparam logic [1:0]  WRITE_DELAY   = 2'h2;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TCC_EDGE_NONE = 2'b00,
		TCC_EDGE_RISE = 2'b01,
		TCC_EDGE_FALL = 2'b10,
		TCC_EDGE_BOTH = 2'b11
	} tcc_edge_type;

	typedef enum logic [1:0] {
		TCC_WAVE_OFF   = 2'b00,
		TCC_WAVE_SETCL = 2'b01,
		TCC_WAVE_TOG_A = 2'b10,
		TCC_WAVE_TOG_B = 2'b11
	} tcc_wave_type;

endpackage

// ===== src/tcc_edge_if.sv
// Connection between the channel and one capture edge detector
`timescale 1ns/1ps
interface tcc_edge_if;
	logic [1:0] edge_select;
	logic       level;
	logic       hit;

	modport detector (input edge_select, input level, output hit);
	modport owner    (output edge_select, output level, input hit);
endinterface

// ===== src/tcc_edge_detect.sv
// Edge detector for one capture trigger input
`timescale 1ns/1ps
module tcc_edge_detect
	import tcc_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	tcc_edge_if.detector port
);

	logic prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= 1'b0;
		end else if (ce) begin
			prev <= port.level;
		end
	end

	always_comb begin
		case (tcc_edge_type'(port.edge_select))
			TCC_EDGE_RISE: port.hit = port.level & ~prev;
			TCC_EDGE_FALL: port.hit = ~port.level & prev;
			TCC_EDGE_BOTH: port.hit = port.level ^ prev;
			default:       port.hit = 1'b0;
		endcase
	end

endmodule // tcc_edge_detect

// ===== src/tcc_channel.sv
// Compare/capture channel of a 16-bit up-counting timer, APB slave
//
// Function
// - B mode bit one makes B capture
// - Capture A edges: 3 both, 2 fall, 1 rise
// - Capture A edge ignored in comparator mode
// - Waveform A mode selects toggle/set/clear events
// - Waveform A mode ignored in capture mode
// - Invert bit gives active-low waveform A
// - A mode bit one makes A capture
// - Unbuffered A write applies two ticks later
// - Buffered A write loads on compare B
// - A reads return active compare value
// - Counter equal A raises compare A
// - Capture A edge loads counter, raises cause
// - Unbuffered B write applies two ticks later
// - Buffered B write loads on compare B
// - B reads return active compare value
// - Counter equal B raises cause, clears counter
// - Capture B edge loads counter, raises cause
// - Six interrupt enable bits, reset zero
// - Capture B edges decoded as A
// - Flags set by events, cleared writing one
// - Recapture before flag cleared sets overwrite
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module tcc_channel
	import tcc_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              count_tick,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              capture_a_input,
	input  wire logic              capture_b_input,
	output logic                   waveform_a_output,
	output logic                   compare_a_signal,
	output logic                   compare_b_signal,
	output logic                   irq_request
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
	                                 input logic [15:0] idx);
		reg_hit = (addr == ADDR_W'({idx, 2'b00}));
	endfunction

	logic [REG_W-1:0] timer_ctl;
	logic [REG_W-1:0] mode_ctl;
	logic [REG_W-1:0] counter;
	logic [IRQ_W-1:0] irq_enable;
	logic [IRQ_W-1:0] irq_flag;
	logic [REG_W-1:0] data_reg [2];
	logic [REG_W-1:0] cmp_buf  [2];
	logic [REG_W-1:0] pend_val [2];
	logic [1:0]       pend_cnt [2];
	logic             wave_state;

	logic             acc_done;
	logic             wr;
	logic             wr_data [2];
	logic             reg_mode [2];
	logic             match [2];
	logic             cap_hit [2];
	logic             tick;
	logic             cnt_clk;
	logic             buf_en;
	logic             mapped;
	logic [REG_W-1:0] rd_mux;
	logic [IRQ_W-1:0] flag_set;
	logic             next_wave;

	assign acc_done = ce & psel & penable & pready;
	assign wr       = acc_done & pwrite;
	assign wr_data[0] = wr & reg_hit(paddr, IDX_A_DATA);
	assign wr_data[1] = wr & reg_hit(paddr, IDX_B_DATA);
	assign reg_mode[0] = mode_ctl[CTL_A_MODE];
	assign reg_mode[1] = mode_ctl[CTL_B_MODE];
	assign tick     = ce & count_tick & timer_ctl[TCTL_RUN];
	// Count clock runs whether or not the counter does
	assign cnt_clk  = ce & count_tick;
	assign buf_en   = timer_ctl[TCTL_BUF];

	// ----------------------------------------------------------------
	// Capture edge detectors and comparators
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_unit
		tcc_edge_if eif ();
		assign eif.edge_select = (i == 0) ? mode_ctl[CTL_A_EDGE +: 2]
		                                  : mode_ctl[CTL_B_EDGE +: 2];
		assign eif.level       = (i == 0) ? capture_a_input : capture_b_input;
		tcc_edge_detect u_edge (
			.pclk    (pclk),
			.presetn (presetn),
			.ce      (ce),
			.port    (eif.detector)
		);
		// Edges count only in capture mode
		assign cap_hit[i] = eif.hit & reg_mode[i];
		assign match[i]   = tick & ~reg_mode[i] & (counter == data_reg[i]);
	end

	// ----------------------------------------------------------------
	// APB slave: one wait state, registered answer
	// ----------------------------------------------------------------
	always_comb begin
		mapped = 1'b1;
		rd_mux = '0;
		if (reg_hit(paddr, IDX_TIMER_CTL)) begin
			rd_mux = timer_ctl;
		end else if (reg_hit(paddr, IDX_COUNTER)) begin
			rd_mux = counter;
		end else if (reg_hit(paddr, IDX_MODE_CTL)) begin
			rd_mux = mode_ctl;
		end else if (reg_hit(paddr, IDX_A_DATA)) begin
			rd_mux = data_reg[0];
		end else if (reg_hit(paddr, IDX_B_DATA)) begin
			rd_mux = data_reg[1];
		end else if (reg_hit(paddr, IDX_IRQ_EN)) begin
			rd_mux = REG_W'(irq_enable);
		end else if (reg_hit(paddr, IDX_IRQ_FLAG)) begin
			rd_mux = REG_W'(irq_flag);
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel & penable & ~pready & ~pwrite) begin
				prdata <= DATA_W'(rd_mux);
			end
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_ctl  <= REG_RESET;
			mode_ctl   <= REG_RESET;
			irq_enable <= IRQ_RESET;
		end else if (wr) begin
			if (reg_hit(paddr, IDX_TIMER_CTL)) begin
				timer_ctl <= pwdata[REG_W-1:0] & TCTL_MASK;
			end
			if (reg_hit(paddr, IDX_MODE_CTL)) begin
				mode_ctl <= pwdata[REG_W-1:0] & MODE_CTL_MASK;
			end
			if (reg_hit(paddr, IDX_IRQ_EN)) begin
				irq_enable <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter <= REG_RESET;
		end else if (tick) begin
			counter <= match[1] ? REG_RESET : counter + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Data registers: compare value, buffer, delayed load, capture
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				data_reg[i] <= REG_RESET;
				cmp_buf[i]  <= REG_RESET;
				pend_val[i] <= REG_RESET;
				pend_cnt[i] <= 2'h0;
			end
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				if (wr_data[i] & ~reg_mode[i] & ~buf_en) begin
					pend_val[i] <= pwdata[REG_W-1:0];
					pend_cnt[i] <= WRITE_DELAY;
				end else if (cnt_clk & (pend_cnt[i] != 2'h0)) begin
					pend_cnt[i] <= pend_cnt[i] - 2'h1;
				end
				// Buffer tracks every compare write, so enabling it keeps the value
				if (wr_data[i] & ~reg_mode[i]) begin
					cmp_buf[i] <= pwdata[REG_W-1:0];
				end
				if (cap_hit[i]) begin
					data_reg[i] <= counter;
				end else if (wr_data[i] & reg_mode[i]) begin
					data_reg[i] <= pwdata[REG_W-1:0];
				end else if (~reg_mode[i] & buf_en & match[1]) begin
					data_reg[i] <= cmp_buf[i];
				end else if (~reg_mode[i] & cnt_clk & (pend_cnt[i] == 2'h1)
				             & ~wr_data[i]) begin
					data_reg[i] <= pend_val[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt flags and request
	// ----------------------------------------------------------------
	always_comb begin
		flag_set            = '0;
		flag_set[IRQ_CMP_A] = match[0];
		flag_set[IRQ_CMP_B] = match[1];
		flag_set[IRQ_CAP_A] = cap_hit[0];
		flag_set[IRQ_CAP_B] = cap_hit[1];
		flag_set[IRQ_OVW_A] = cap_hit[0] & irq_flag[IRQ_CAP_A];
		flag_set[IRQ_OVW_B] = cap_hit[1] & irq_flag[IRQ_CAP_B];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_flag <= IRQ_RESET;
		end else if (ce) begin
			// Set wins over a same-cycle clear
			if (wr & reg_hit(paddr, IDX_IRQ_FLAG)) begin
				irq_flag <= (irq_flag & ~pwdata[IRQ_W-1:0]) | flag_set;
			end else begin
				irq_flag <= irq_flag | flag_set;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_request <= 1'b0;
		end else if (ce) begin
			irq_request <= |(irq_flag & irq_enable);
		end
	end

	// ----------------------------------------------------------------
	// Compare strobes and waveform A
	// ----------------------------------------------------------------
	always_comb begin
		next_wave = wave_state;
		if (reg_mode[0]) begin
			next_wave = 1'b0;
		end else begin
			case (tcc_wave_type'(mode_ctl[CTL_A_WAVE +: 2]))
				TCC_WAVE_TOG_B: next_wave = wave_state ^ match[1];
				TCC_WAVE_TOG_A: next_wave = wave_state ^ match[0];
				TCC_WAVE_SETCL: begin
					if (match[1]) begin
						next_wave = 1'b0;
					end else if (match[0]) begin
						next_wave = 1'b1;
					end
				end
				default: next_wave = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_state        <= 1'b0;
			waveform_a_output <= 1'b0;
			compare_a_signal  <= 1'b0;
			compare_b_signal  <= 1'b0;
		end else if (ce) begin
			wave_state        <= next_wave;
			waveform_a_output <= next_wave ^ (mode_ctl[CTL_A_INV] & ~reg_mode[0]);
			compare_a_signal  <= match[0];
			compare_b_signal  <= match[1];
		end
	end

endmodule // tcc_channel

// ===== sim/tcc_channel_sva.sv
// Port assertions for the compare/capture channel
`timescale 1ns/1ps
module tcc_channel_sva
	import tcc_pkg::*;
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              count_tick,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              waveform_a_output,
	input wire logic              compare_a_signal,
	input wire logic              compare_b_signal
);
	// ----------------------------------------------------------------
	// Bus and event checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready high for more than one cycle");
	a_one_wait: assert property (psel && !penable |-> ##2 pready)
		else $error("access not answered after one wait state");
	a_ready_access: assert property (pready |-> psel && penable && $past(psel))
		else $error("pready outside an access phase");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	a_cmp_a_tick: assert property (compare_a_signal |-> $past(count_tick))
		else $error("compare A not one cycle after a tick");
	a_cmp_b_tick: assert property (
		$rose(compare_b_signal) |-> $past(count_tick) ##1 !compare_b_signal)
		else $error("compare B pulse malformed");
	a_wave_cause: assert property ($changed(waveform_a_output) |->
		compare_a_signal || compare_b_signal || $past(pready && pwrite)
		|| $past(pready && pwrite, 2))
		else $error("waveform A changed without cause");
endmodule // tcc_channel_sva

// ===== sim/tcc_trigger_model.sv
// Capture trigger source and interrupt receiver
`timescale 1ns/1ps
module tcc_trigger_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic level_a,
	input  wire logic level_b,
	input  wire logic irq_request,
	output logic      capture_a_input,
	output logic      capture_b_input,
	output int        irq_count
);
	logic irq_seen;

	// ----------------------------------------------------------------
	// Triggers move after an edge; rising requests are counted
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_a_input <= 1'b0;
			capture_b_input <= 1'b0;
			irq_seen <= 1'b0;
			irq_count <= 0;
		end else begin
			capture_a_input <= level_a;
			capture_b_input <= level_b;
			irq_seen <= irq_request;
			if (irq_request && !irq_seen)
				irq_count <= irq_count + 1;
		end
	end
endmodule // tcc_trigger_model

// ===== sim/tb_tcc_channel.sv
// Self-checking bench for the compare/capture channel
`timescale 1ns/1ps
module tb_tcc_channel
	import tcc_pkg::*;
();
	logic pclk, presetn, ce, count_tick, psel, penable, pwrite, pready, pslverr;
	logic capture_a_input, capture_b_input, waveform_a_output, irq_request;
	logic compare_a_signal, compare_b_signal, level_a, level_b, serr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic [15:0]       rdat;
	int                irq_count, error_cnt, comparisons, n;

	tcc_channel i_dut (.pclk, .presetn, .ce, .count_tick, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .capture_a_input, .capture_b_input,
		.waveform_a_output, .compare_a_signal, .compare_b_signal, .irq_request);
	tcc_trigger_model i_trig (.pclk, .presetn, .level_a, .level_b, .irq_request,
		.capture_a_input, .capture_b_input, .irq_count);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) count_tick <= ~count_tick;

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("Comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [15:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			error_cnt++;
			test_done();
		end
		rdat = prdata[15:0];
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [15:0] d);
		xfer(1'b1, idx, d);
	endtask
	task automatic rd(input string s, input logic [15:0] idx, input logic [15:0] e);
		xfer(1'b0, idx, 16'h0000);
		chk(s, e, rdat);
	endtask
	// Cycles until the next compare pulse, B when b is set
	task automatic gap(input logic b);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((b ? compare_b_signal : compare_a_signal) !== 1'b1 && n < 200);
		if (n >= 200) begin
			error_cnt++;
			test_done();
		end
	endtask
	task automatic wave(input logic [15:0] m, input logic [15:0] e);
		wr(IDX_MODE_CTL, m);
		repeat (4) @(posedge pclk);
		chk("wave", e, 16'(waveform_a_output));
	endtask

	initial begin
		{presetn, psel, penable, pwrite, count_tick, level_a, level_b} = 7'h00;
		{ce, paddr, pwdata} = {1'b1, 20'h00000, 32'h00000000};
		{error_cnt, comparisons} = {0, 0};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd("a_data", IDX_A_DATA, 16'h0000);
		rd("mode", IDX_MODE_CTL, 16'h0000);
		rd("irq_en", IDX_IRQ_EN, 16'h0000);
		wr(IDX_IRQ_EN, 16'hFFFF);
		rd("irq_en", IDX_IRQ_EN, 16'h003F);
		wr(IDX_IRQ_EN, 16'h0000);
		xfer(1'b0, 16'h5500, 16'h0000);
		chk("slverr", 16'h0001, 16'(serr));
		for (int e = 0; e < 4; e++) begin
			wr(IDX_MODE_CTL, {8'h00, 2'(e), 6'h01});
			wr(IDX_A_DATA, 16'h1234);
			wr(IDX_IRQ_FLAG, 16'h003F);
			level_a <= 1'b1;
			repeat (4) @(posedge pclk);
			rd("cap_a", IDX_A_DATA, e[0] ? 16'h0000 : 16'h1234);
			wr(IDX_IRQ_FLAG, 16'h003F);
			level_a <= 1'b0;
			repeat (4) @(posedge pclk);
			xfer(1'b0, IDX_IRQ_FLAG, 16'h0000);
			chk("fall_flag", 16'(e[1]), 16'(rdat[2]));
		end
		level_a <= 1'b1;
		repeat (4) @(posedge pclk);
		wr(IDX_IRQ_FLAG, 16'h0000);
		wr(IDX_IRQ_FLAG, 16'h0004);
		xfer(1'b0, IDX_IRQ_FLAG, 16'h0000);
		chk("overwrite", 16'h0010, rdat & 16'h0014);
		wr(IDX_MODE_CTL, 16'h00C0);
		wr(IDX_A_DATA, 16'h0004);
		wr(IDX_IRQ_FLAG, 16'h003F);
		level_a <= 1'b0;
		repeat (6) @(posedge pclk);
		xfer(1'b0, IDX_IRQ_FLAG, 16'h0000);
		chk("cmp_edge", 16'h0000, rdat & 16'h0014);
		rd("a_cmp", IDX_A_DATA, 16'h0004);
		wr(IDX_MODE_CTL, 16'h8100);
		wr(IDX_B_DATA, 16'h5555);
		level_b <= 1'b1;
		repeat (6) @(posedge pclk);
		rd("b_rise", IDX_B_DATA, 16'h5555);
		level_b <= 1'b0;
		repeat (6) @(posedge pclk);
		rd("b_fall", IDX_B_DATA, 16'h0000);
		n = irq_count;
		wr(IDX_IRQ_EN, 16'h0008);
		repeat (3) @(posedge pclk);
		chk("irq_count", 16'(n + 1), 16'(irq_count));
		wr(IDX_IRQ_EN, 16'h0000);
		repeat (3) @(posedge pclk);
		chk("irq_mask", 16'h0000, 16'(irq_request));
		wave(16'h0002, 16'h0001);
		wave(16'h0003, 16'h0000);
		wr(IDX_MODE_CTL, 16'h0010);
		wr(IDX_B_DATA, 16'h0009);
		wr(IDX_IRQ_FLAG, 16'h003F);
		wr(IDX_TIMER_CTL, 16'h0001);
		repeat (60) @(posedge pclk);
		rd("b_cmp", IDX_B_DATA, 16'h0009);
		xfer(1'b0, IDX_IRQ_FLAG, 16'h0000);
		chk("cmp_flags", 16'h0003, rdat & 16'h0003);
		gap(1'b1);
		chk("wave_fall_b", 16'h0000, 16'(waveform_a_output));
		gap(1'b0);
		chk("a_after_b", 16'h000A, 16'(n));
		chk("wave_rise_a", 16'h0001, 16'(waveform_a_output));
		gap(1'b1);
		chk("b_rest", 16'h000A, 16'(n));
		wr(IDX_TIMER_CTL, 16'h0003);
		gap(1'b1);
		wr(IDX_A_DATA, 16'h0006);
		wr(IDX_B_DATA, 16'h000B);
		rd("a_active", IDX_A_DATA, 16'h0004);
		repeat (60) @(posedge pclk);
		rd("a_loaded", IDX_A_DATA, 16'h0006);
		rd("b_loaded", IDX_B_DATA, 16'h000B);
		gap(1'b1);
		gap(1'b0);
		chk("a_after_b_buf", 16'h000E, 16'(n));
		gap(1'b1);
		chk("b_rest_buf", 16'h000A, 16'(n));
		wr(IDX_MODE_CTL, 16'h0020);
		gap(1'b0);
		rdat = 16'(waveform_a_output);
		gap(1'b1);
		chk("tog_a_hold", rdat, 16'(waveform_a_output));
		gap(1'b0);
		chk("tog_a", rdat ^ 16'h0001, 16'(waveform_a_output));
		wr(IDX_MODE_CTL, 16'h0030);
		gap(1'b1);
		rdat = 16'(waveform_a_output);
		gap(1'b0);
		chk("tog_b_hold", rdat, 16'(waveform_a_output));
		gap(1'b1);
		chk("tog_b", rdat ^ 16'h0001, 16'(waveform_a_output));
		ce <= 1'b0;
		repeat (40) @(posedge pclk);
		ce <= 1'b1;
		gap(1'b0);
		chk("ce_freeze", 16'h000E, 16'(n));
		test_done();
	end
endmodule // tb_tcc_channel

bind tcc_channel tcc_channel_sva i_sva (.pclk, .presetn, .count_tick, .psel, .penable,
	.pwrite, .prdata, .pready, .pslverr, .waveform_a_output, .compare_a_signal,
	.compare_b_signal);
